// ===== core/ifr_top.sv
// info-entry router: bus slave, entry FIFO, routing, output-FIFO pointers
// Behaviour
// RQ1 - the alternate-source bit picks one of two meanings of the source type.
// RQ2 - the 12-bit byte count sets how many bytes an entry moves; bigger transfers take several entries.
// RQ3 - the auxiliary FIFO accepts data only from an immediate load to 78h or a move to Fh.
// RQ4 - software queues the entry that drains auxiliary data before filling it, or the router waits.
// RQ5 - the output FIFO keeps separate alignment and DMA read pointers.
// RQ6 - in independent mode a pointer that would pass the writer stops until it moves on.
// RQ7 - with no DMA reads and more data than the output FIFO holds, the entry stalls for good.
// RQ8 - output source with the alternate bit set keeps both pointers moving together.
// RQ9 - out-snooping feeds class 1 from the input FIFO and class 2 from the output FIFO.
// RQ10 - auxiliary snooping feeds class 1 from the auxiliary FIFO and class 2 from the output FIFO.
// RQ11 - a set boundary bit on a padding entry pads out to a 16-byte boundary.
// RQ12 - padding fields apply only to source type 10b.
// RQ13 - the padding entry may be written only while request and grant are both set.
// RQ14 - padding entries use the destination, flag, type, boundary and pad-kind layout.
// RQ15 - destination 00 is the controller, 01 class 1, 10 class 2, 11 both; only skip or message go to 00.
// RQ16 - a class 1 final flag flushes the class 1 alignment block after the entry.
// RQ17 - entries run strictly in order, one byte count finished before the next.
`timescale 1ns/10ps

module ifr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;

  assign level = wp_q - rp_q;
  assign in_ready = level != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule // ifr_fifo

module ifr_top #(
  parameter int ENTRY_DEPTH = 16,
  parameter int OFIFO_BYTES = 64,
  parameter int AUX_BYTES = 64
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_byte_avail,
  input wire logic c1_ready,
  input wire logic c2_ready,
  input wire logic ofifo_push,
  input wire logic dma_pop,
  output logic in_pop_q,
  output logic c1_take_q,
  output logic c2_take_q,
  output ifr_pkg::ifr_src_t c1_src_q,
  output ifr_pkg::ifr_src_t c2_src_q,
  output logic [2:0] pad_kind_q,
  output logic [3:0] payload_kind_q,
  output logic drop_q,
  output logic c1_flush_q,
  output logic c2_flush_q,
  output logic c2_size_ready_q,
  output logic ofifo_full_q,
  output logic dma_avail_q,
  output logic busy_q
);
  localparam int OPW = $clog2(OFIFO_BYTES);
  localparam int XW = $clog2(AUX_BYTES);

  function automatic ifr_pkg::ifr_route_t route_of(input ifr_pkg::ifr_entry_t e);
    logic alt;
    alt = e.low[ifr_pkg::ALT_BIT];
    route_of = '{c1_src: ifr_pkg::SRC_IN, c2_src: ifr_pkg::SRC_IN, sync_ptrs: 1'b0};
    unique case (e.source_type)
      ifr_pkg::ST_IN: begin
        route_of.c1_src = alt ? ifr_pkg::SRC_AUX : ifr_pkg::SRC_IN; // RQ1
        route_of.c2_src = route_of.c1_src;
      end
      ifr_pkg::ST_OUT: begin
        route_of.c1_src = ifr_pkg::SRC_OUT;
        route_of.c2_src = ifr_pkg::SRC_OUT;
        route_of.sync_ptrs = alt; // RQ8
      end
      ifr_pkg::ST_PAD: begin
        route_of.c1_src = ifr_pkg::SRC_PAD; // RQ12
        route_of.c2_src = e.low[ifr_pkg::PSNOOP_BIT] ? ifr_pkg::SRC_OUT : ifr_pkg::SRC_PAD; // RQ14
      end
      ifr_pkg::ST_SNOOP: begin
        route_of.c1_src = alt ? ifr_pkg::SRC_AUX : ifr_pkg::SRC_IN; // RQ9 RQ10
        route_of.c2_src = ifr_pkg::SRC_OUT; // RQ9 RQ10
      end
    endcase
  endfunction

  // bus write side
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic req_q, gnt_q, move_q, err_q;
  logic [7:0] tgt_q;
  wire logic wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire logic wr_entry = aw_addr_q == ifr_pkg::OFF_ENTRY;
  wire logic wr_ctrl = aw_addr_q == ifr_pkg::OFF_CTRL;
  wire logic wr_auxcmd = aw_addr_q == ifr_pkg::OFF_AUXCMD;
  wire logic wr_auxdata = aw_addr_q == ifr_pkg::OFF_AUXDATA;
  wire logic wr_status = aw_addr_q == ifr_pkg::OFF_STATUS;
  wire logic granted = req_q & gnt_q; // RQ13
  wire logic aux_tgt_ok = move_q ? (tgt_q == ifr_pkg::TGT_MOVE_AUX)
                                 : (tgt_q == ifr_pkg::TGT_LOAD_AUX); // RQ3
  logic [XW:0] aux_bytes_q;
  wire logic aux_room = aux_bytes_q <= (XW+1)'(AUX_BYTES - 4);
  wire logic aux_fill = wr_go & wr_auxdata & aux_tgt_ok & aux_room; // RQ3
  logic ef_in_ready, ef_out_valid, ef_pop;
  logic [31:0] ef_out;
  logic [$clog2(ENTRY_DEPTH):0] ef_level;
  wire logic entry_push = wr_go & wr_entry & granted;
  // an entry write waits in the bus while the entry FIFO is full
  wire logic wr_done = wr_go & ~(entry_push & ~ef_in_ready);
  wire logic wr_bad = wr_entry ? ~granted : wr_auxdata ? ~(aux_tgt_ok & aux_room)
                    : ~(wr_ctrl | wr_auxcmd | wr_status);

  ifr_fifo #(.WIDTH(32), .DEPTH(ENTRY_DEPTH)) u_entry_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(w_data_q),
    .in_valid(entry_push),
    .in_ready(ef_in_ready),
    .out_data(ef_out),
    .out_valid(ef_out_valid),
    .out_ready(ef_pop),
    .level(ef_level)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_q <= '0;
      w_data_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ifr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_done) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
      end else if (wr_done) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_done) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? ifr_pkg::RESP_SLVERR : ifr_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // routing engine
  ifr_pkg::ifr_state_t state_q, state_d;
  ifr_pkg::ifr_entry_t cur_q;
  ifr_pkg::ifr_route_t rt_q;
  localparam int CNT_W_L = ifr_pkg::CNT_W;
  localparam int LEN_W_L = ifr_pkg::LEN_W;
  localparam logic [4:0] PAD16 = ifr_pkg::PAD_BOUNDARY;
  logic [CNT_W_L-1:0] cnt_q;
  logic [OPW:0] wr_ptr_q, ab_ptr_q, dma_ptr_q;
  wire ifr_pkg::ifr_entry_t head = ef_out;
  wire ifr_pkg::ifr_route_t head_rt = route_of(head);
  wire logic head_pad = head.source_type == ifr_pkg::ST_PAD;
  wire logic head_ctrl = head.route_target == ifr_pkg::ROUTE_TARGET_CTRL;
  wire logic head_bad = head_ctrl & (head.payload_kind != ifr_pkg::KIND_SKIP)
                      & (head.payload_kind != ifr_pkg::KIND_MSG); // RQ15
  wire logic [3:0] res16 = head.low[3:0];
  // boundary padding fills the remainder of the current 16-byte block
  wire logic [CNT_W_L-1:0] pad_cnt = head.boundary_pad_en
    ? CNT_W_L'(PAD16 - {1'b0, res16}) : CNT_W_L'(head.low[6:0]); // RQ11
  wire logic [CNT_W_L-1:0] head_cnt = head_bad ? '0
    : head_pad ? pad_cnt : CNT_W_L'(head.low[LEN_W_L-1:0]); // RQ2 RQ12
  wire logic use1 = cur_q.route_target[0] | (cur_q.route_target == ifr_pkg::ROUTE_TARGET_CTRL); // RQ15
  wire logic use2 = cur_q.route_target[1]; // RQ15
  wire logic need_in = (use1 & rt_q.c1_src == ifr_pkg::SRC_IN) | (use2 & rt_q.c2_src == ifr_pkg::SRC_IN);
  wire logic need_out = (use1 & rt_q.c1_src == ifr_pkg::SRC_OUT) | (use2 & rt_q.c2_src == ifr_pkg::SRC_OUT);
  wire logic need_aux = (use1 & rt_q.c1_src == ifr_pkg::SRC_AUX) | (use2 & rt_q.c2_src == ifr_pkg::SRC_AUX);
  wire logic out_avail = ab_ptr_q != wr_ptr_q; // RQ6
  wire logic dma_has = dma_ptr_q != wr_ptr_q;
  // missing aux or output data simply holds the entry, which is where a misordered fill hangs
  wire logic step = (state_q == ifr_pkg::ST_RUN) & (~need_in | in_byte_avail)
    & (~need_out | out_avail) & (~need_aux | (aux_bytes_q != '0)) // RQ4 RQ6 RQ7
    & (~use2 | c2_ready) & (~cur_q.route_target[0] | c1_ready);
  wire logic last_step = step & (cnt_q == CNT_W_L'(1));
  wire logic ab_adv = step & need_out; // RQ5
  wire logic sync_run = rt_q.sync_ptrs & (state_q == ifr_pkg::ST_RUN); // RQ8
  wire logic dma_adv = ~sync_run & dma_pop & dma_has; // RQ5
  wire logic [OPW:0] fill_ab = wr_ptr_q - ab_ptr_q;
  wire logic [OPW:0] fill_dma = wr_ptr_q - dma_ptr_q;
  wire logic of_full = (fill_ab == (OPW+1)'(OFIFO_BYTES)) | (fill_dma == (OPW+1)'(OFIFO_BYTES)); // RQ6
  wire logic of_wr = ofifo_push & ~of_full;
  assign ef_pop = (state_q == ifr_pkg::ST_IDLE) & ef_out_valid; // RQ17

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ifr_pkg::ST_IDLE: if (ef_pop) state_d = (head_cnt == '0) ? ifr_pkg::ST_FIN : ifr_pkg::ST_RUN;
      ifr_pkg::ST_RUN: if (last_step) state_d = ifr_pkg::ST_FIN; // RQ17
      ifr_pkg::ST_FIN: state_d = ifr_pkg::ST_IDLE;
      default: state_d = ifr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ifr_pkg::ST_IDLE;
      cur_q <= '0;
      rt_q <= '0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (ef_pop) begin
        cur_q <= head;
        rt_q <= head_rt;
        cnt_q <= head_cnt;
      end else if (step) begin
        cnt_q <= cnt_q - CNT_W_L'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      ab_ptr_q <= '0;
      dma_ptr_q <= '0;
      aux_bytes_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (OPW+1)'(of_wr);
      ab_ptr_q <= ab_ptr_q + (OPW+1)'(ab_adv);
      dma_ptr_q <= sync_run ? ab_ptr_q + (OPW+1)'(ab_adv) : dma_ptr_q + (OPW+1)'(dma_adv); // RQ8
      aux_bytes_q <= aux_bytes_q + (aux_fill ? (XW+1)'(4) : '0) - (XW+1)'(step & need_aux);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_pop_q <= 1'b0;
      c1_take_q <= 1'b0;
      c2_take_q <= 1'b0;
      c1_src_q <= ifr_pkg::SRC_IN;
      c2_src_q <= ifr_pkg::SRC_IN;
      pad_kind_q <= '0;
      payload_kind_q <= '0;
      drop_q <= 1'b0;
      c1_flush_q <= 1'b0;
      c2_flush_q <= 1'b0;
      c2_size_ready_q <= 1'b0;
      ofifo_full_q <= 1'b0;
      dma_avail_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      in_pop_q <= step & need_in;
      c1_take_q <= step & cur_q.route_target[0];
      c2_take_q <= step & use2;
      drop_q <= step & (cur_q.route_target == ifr_pkg::ROUTE_TARGET_CTRL);
      c1_src_q <= rt_q.c1_src;
      c2_src_q <= rt_q.c2_src;
      pad_kind_q <= cur_q.pad_kind;
      payload_kind_q <= cur_q.payload_kind;
      c1_flush_q <= (state_q == ifr_pkg::ST_FIN) & (cur_q.final_class1 | cur_q.flush_class1); // RQ16
      c2_flush_q <= (state_q == ifr_pkg::ST_FIN) & (cur_q.final_class2 | cur_q.flush_class2);
      c2_size_ready_q <= (state_q == ifr_pkg::ST_FIN) & cur_q.final_class2;
      ofifo_full_q <= of_full | (ofifo_push & ((fill_ab == (OPW+1)'(OFIFO_BYTES - 1))
                      | (fill_dma == (OPW+1)'(OFIFO_BYTES - 1))));
      dma_avail_q <= ~rt_q.sync_ptrs & (fill_dma > (OPW+1)'(dma_pop));
      busy_q <= state_d != ifr_pkg::ST_IDLE;
    end
  end

  // control registers; a bad controller entry sets the error, which beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= ifr_pkg::CTRL_RESET[ifr_pkg::CTRL_REQ_BIT];
      gnt_q <= ifr_pkg::CTRL_RESET[ifr_pkg::CTRL_GNT_BIT];
      tgt_q <= '0;
      move_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (wr_done & wr_ctrl) req_q <= w_data_q[ifr_pkg::CTRL_REQ_BIT];
      gnt_q <= req_q;
      if (wr_done & wr_auxcmd) begin
        tgt_q <= w_data_q[7:0];
        move_q <= w_data_q[ifr_pkg::AUXCMD_MOVE_BIT];
      end
      if (ef_pop & head_bad) err_q <= 1'b1; // RQ15
      else if (wr_done & wr_status & w_data_q[ifr_pkg::ST_ERR_BIT]) err_q <= 1'b0;
    end
  end

  // bus read side
  wire logic [31:0] status_word = {err_q, (state_q == ifr_pkg::ST_RUN) & ~step, state_q,
    12'h000, 8'(aux_bytes_q), 3'h0, 5'(ef_level)};
  wire logic rd_ok = (s_axi_araddr == ifr_pkg::OFF_CTRL) | (s_axi_araddr == ifr_pkg::OFF_AUXCMD)
                   | (s_axi_araddr == ifr_pkg::OFF_STATUS);
  wire logic [31:0] rd_word = (s_axi_araddr == ifr_pkg::OFF_CTRL) ? {30'h0, gnt_q, req_q}
    : (s_axi_araddr == ifr_pkg::OFF_AUXCMD) ? {23'h0, move_q, tgt_q}
    : (s_axi_araddr == ifr_pkg::OFF_STATUS) ? status_word : 32'h0000_0000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= ifr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? ifr_pkg::RESP_OKAY : ifr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // ifr_top

// ===== inc/ifr_pkg.sv
// shared constants and types of the info-entry router
package ifr_pkg;
  localparam logic [7:0] OFF_ENTRY = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_AUXCMD = 8'h08;
  localparam logic [7:0] OFF_AUXDATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ALT_BIT = 14;
  localparam int PSNOOP_BIT = 10;
  localparam int LEN_W = 12;
  localparam int CNT_W = 13;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_GNT_BIT = 1;
  localparam int AUXCMD_MOVE_BIT = 8;
  localparam int ST_ERR_BIT = 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [4:0] PAD_BOUNDARY = 5'h10;
  localparam logic [7:0] TGT_LOAD_AUX = 8'h78;
  localparam logic [7:0] TGT_MOVE_AUX = 8'h0F;
  localparam logic [3:0] KIND_SKIP = 4'hE;
  localparam logic [3:0] KIND_MSG = 4'hF;
  localparam logic [1:0] ROUTE_TARGET_CTRL = 2'h0;
  localparam logic [1:0] ST_IN = 2'h0;
  localparam logic [1:0] ST_OUT = 2'h1;
  localparam logic [1:0] ST_PAD = 2'h2;
  localparam logic [1:0] ST_SNOOP = 2'h3;

  typedef enum logic [1:0] {
    SRC_IN = 2'h0,
    SRC_OUT = 2'h1,
    SRC_PAD = 2'h2,
    SRC_AUX = 2'h3
  } ifr_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_FIN = 2'h3
  } ifr_state_t;

  typedef struct packed {
    logic [1:0] route_target;
    logic final_class2;
    logic final_class1;
    logic flush_class2;
    logic flush_class1;
    logic [1:0] source_type;
    logic [3:0] payload_kind;
    logic boundary_pad_en;
    logic [2:0] pad_kind;
    logic [15:0] low;
  } ifr_entry_t;

  typedef struct packed {
    ifr_src_t c1_src;
    ifr_src_t c2_src;
    logic sync_ptrs;
  } ifr_route_t;
endpackage

// ===== verif/ifr_chk_props.sv
// concurrent checks on the info-entry router ports
`timescale 1ns/10ps
module ifr_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_pop_q,
  input wire logic c1_take_q,
  input wire logic c2_take_q,
  input wire ifr_pkg::ifr_src_t c1_src_q,
  input wire ifr_pkg::ifr_src_t c2_src_q,
  input wire logic drop_q,
  input wire logic c1_flush_q,
  input wire logic c2_flush_q,
  input wire logic c2_size_ready_q,
  input wire logic busy_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read answer changed before it was taken");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read address taken during answer");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  wr_free_a: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write channels not reopened with the response");
  drop_excl_a: assert property (drop_q |-> !c1_take_q && !c2_take_q)
    else $error("dropped byte also handed to an engine");
  flush_pulse_a: assert property (c1_flush_q |=> !c1_flush_q)
    else $error("class 1 flush longer than one cycle");
  size_flush_a: assert property (c2_size_ready_q |-> c2_flush_q)
    else $error("class 2 size ready without flush");
  pop_source_a: assert property (in_pop_q |-> c1_src_q == ifr_pkg::SRC_IN || c2_src_q == ifr_pkg::SRC_IN)
    else $error("input byte consumed by entry without input source");
  take_busy_a: assert property (c1_take_q || c2_take_q |-> busy_q || $past(busy_q))
    else $error("byte handed out with no entry in progress");
endmodule // ifr_chk

// ===== verif/ifr_far_model.sv
// far-side model: input FIFO, class engines, output FIFO writer and DMA reader
`timescale 1ns/10ps
module ifr_far_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic push_en,
  input wire logic dma_en,
  input wire logic ofifo_full_q,
  input wire logic dma_avail_q,
  output logic in_byte_avail,
  output logic c1_ready,
  output logic c2_ready,
  output logic ofifo_push,
  output logic dma_pop
);
  logic [1:0] tick_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 2'h0;
      in_byte_avail <= 1'h0;
      c1_ready <= 1'h0;
      c2_ready <= 1'h0;
      ofifo_push <= 1'h0;
      dma_pop <= 1'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
      in_byte_avail <= ~slow | tick_q[0];
      c1_ready <= ~slow | tick_q[1];
      c2_ready <= ~slow | (tick_q != 2'h2);
      ofifo_push <= push_en & ~ofifo_full_q;
      // avail lags a cycle, so pop every other cycle at most
      dma_pop <= dma_en & dma_avail_q & ~dma_pop;
    end
  end
endmodule // ifr_far_model

// ===== verif/tb.sv
// self-checking bench of the info-entry router
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [31:0] entry;
    logic slow;
    int n[7];
    logic [3:0] s;
  } ifr_row_t;
  localparam int LIMIT = 60000;
  logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic in_byte_avail, c1_ready, c2_ready, ofifo_push, dma_pop, slow, push_en, dma_en;
  logic in_pop_q, c1_take_q, c2_take_q, drop_q, c1_flush_q, c2_flush_q, c2_size_ready_q;
  logic ofifo_full_q, dma_avail_q, busy_q;
  logic [2:0] pk, lpk;
  logic [3:0] dk;
  logic [6:0] ev;
  ifr_pkg::ifr_src_t c1_src_q, c2_src_q, lc1, lc2;
  int miscompares, samples_checked, cyc;
  int cnt[7], snapv[7];
  ifr_row_t rows[13];
  assign ev = {c2_size_ready_q, c2_flush_q, c1_flush_q, in_pop_q, drop_q, c2_take_q, c1_take_q};
  ifr_top i_dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_byte_avail(in_byte_avail),
    .c1_ready(c1_ready), .c2_ready(c2_ready), .ofifo_push(ofifo_push), .dma_pop(dma_pop),
    .in_pop_q(in_pop_q), .c1_take_q(c1_take_q), .c2_take_q(c2_take_q), .c1_src_q(c1_src_q),
    .c2_src_q(c2_src_q), .pad_kind_q(pk), .payload_kind_q(dk), .drop_q(drop_q), .c1_flush_q(c1_flush_q),
    .c2_flush_q(c2_flush_q), .c2_size_ready_q(c2_size_ready_q), .ofifo_full_q(ofifo_full_q),
    .dma_avail_q(dma_avail_q), .busy_q(busy_q));
  ifr_far_model i_far (.clk(clk), .arst_n(arst_n), .slow(slow), .push_en(push_en), .dma_en(dma_en),
    .ofifo_full_q(ofifo_full_q), .dma_avail_q(dma_avail_q), .in_byte_avail(in_byte_avail),
    .c1_ready(c1_ready), .c2_ready(c2_ready), .ofifo_push(ofifo_push), .dma_pop(dma_pop));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // pulses counted at the falling edge, where registered outputs are settled
  always @(negedge clk) begin
    for (int i = 0; i < 7; i++) cnt[i] += int'(ev[i] === 1'h1);
    if (c1_take_q === 1'h1) lc1 = c1_src_q;
    if (c2_take_q === 1'h1) lc2 = c2_src_q;
    if (c2_take_q === 1'h1) lpk = pk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tk;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tk = 1'h0;
    r = 2'h3;
    for (int k = 0; k < 5000 && !tk; k++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid & bready;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tk) bready <= 1'h0;
    end
    chk(32'(r), 32'(er));
  endtask
  // rready is raised only once the answer shows, so a waiting answer is exercised
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ta, rv, rr;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rv = 1'h0;
    rr = 1'h0;
    r = 2'h3;
    for (int k = 0; k < 100 && !(rv && rr); k++) begin
      @(negedge clk);
      ta = arvalid & arready;
      rv = rvalid;
      rr = rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      rready <= rv & ~rr;
    end
    chk(32'(r), 32'(er));
  endtask
  task automatic wait_idle(input int lim);
    int q;
    q = 0;
    for (int k = 0; k < lim && q < 4; k++) begin
      @(negedge clk);
      q = (busy_q === 1'h0) ? q + 1 : 0;
    end
    chk(32'(q), 32'h4);
  endtask
  task automatic verify(input ifr_row_t r);
    for (int i = 0; i < 7; i++) chk(32'(cnt[i] - snapv[i]), 32'(r.n[i]));
    if (r.n[0] > 0) chk(32'(lc1), 32'(r.s[3:2]));
    if (r.n[1] > 0) chk(32'(lc2), 32'(r.s[1:0]));
  endtask
  task automatic finish_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    arst_n = 1'h0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, slow, dma_en} = '0;
    push_en = 1'h1;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    // counts: c1, c2, drop, in pop, c1 flush, c2 flush, c2 size; source pair {c1, c2}
    rows = '{'{32'h40F0_0005, 0, '{5, 0, 0, 5, 0, 0, 0}, 4'h0}, '{32'hF0F0_0003, 1, '{3, 3, 0, 3, 1, 1, 1}, 4'h0},
      '{32'h00E0_0004, 0, '{0, 0, 4, 4, 0, 0, 0}, 4'h0}, '{32'h00F0_0002, 0, '{0, 0, 2, 2, 0, 0, 0}, 4'h0},
      '{32'h8208_0003, 0, '{0, 13, 0, 0, 0, 0, 0}, 4'h2}, '{32'h88F0_0002, 0, '{0, 2, 0, 2, 0, 1, 0}, 4'h0},
      '{32'h40F0_0000, 0, '{0, 0, 0, 0, 0, 0, 0}, 4'h0}, '{32'h40F0_0FFF, 0, '{4095, 0, 0, 4095, 0, 0, 0}, 4'h0},
      '{32'h41F0_0006, 1, '{6, 0, 0, 0, 0, 0, 0}, 4'h4}, '{32'h41F0_4006, 0, '{6, 0, 0, 0, 0, 0, 0}, 4'h4},
      '{32'hC3F0_0004, 0, '{4, 4, 0, 4, 0, 0, 0}, 4'h1}, '{32'h4200_0005, 0, '{5, 0, 0, 0, 0, 0, 0}, 4'h8},
      '{32'h8205_0007, 1, '{0, 7, 0, 0, 0, 0, 0}, 4'h2}};
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    rd(ifr_pkg::OFF_CTRL, ifr_pkg::RESP_OKAY);
    chk(d, ifr_pkg::CTRL_RESET);
    wr(ifr_pkg::OFF_ENTRY, 32'h40F0_0001, ifr_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1234_5678, ifr_pkg::RESP_SLVERR);
    rd(8'h20, ifr_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(ifr_pkg::OFF_CTRL, 32'h1, ifr_pkg::RESP_OKAY);
    rd(ifr_pkg::OFF_CTRL, ifr_pkg::RESP_OKAY);
    chk(d, 32'h3);
    foreach (rows[i]) begin
      @(posedge clk);
      slow <= rows[i].slow;
      snapv = cnt;
      wr(ifr_pkg::OFF_ENTRY, rows[i].entry, ifr_pkg::RESP_OKAY);
      wait_idle(9000);
      verify(rows[i]);
    end
    chk(32'(lpk), 32'h5);
    @(posedge clk);
    slow <= 1'h0;
    dma_en <= 1'h0;
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'h41F0_00C8, ifr_pkg::RESP_OKAY);
    repeat (400) @(negedge clk);
    chk(32'(busy_q), 32'h1);
    rd(ifr_pkg::OFF_STATUS, ifr_pkg::RESP_OKAY);
    chk(d & 32'h4000_0000, 32'h4000_0000);
    for (int i = 0; i < 16; i++) wr(ifr_pkg::OFF_ENTRY, 32'h40F0_0000, ifr_pkg::RESP_OKAY);
    rd(ifr_pkg::OFF_STATUS, ifr_pkg::RESP_OKAY);
    chk(d & 32'h1F, 32'h10);
    fork
      wr(ifr_pkg::OFF_ENTRY, 32'h40F0_0000, ifr_pkg::RESP_OKAY);
      begin
        repeat (40) @(negedge clk);
        chk(32'(bvalid), 32'h0);
        @(posedge clk);
        dma_en <= 1'h1;
      end
    join
    wait_idle(9000);
    verify('{32'h0, 0, '{200, 0, 0, 0, 0, 0, 0}, 4'h4});
    repeat (100) @(posedge clk);
    dma_en <= 1'h0;
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'h41F0_40C8, ifr_pkg::RESP_OKAY);
    wait_idle(2000);
    verify('{32'h0, 0, '{200, 0, 0, 0, 0, 0, 0}, 4'h4});
    @(posedge clk);
    dma_en <= 1'h1;
    wr(ifr_pkg::OFF_AUXCMD, 32'h78, ifr_pkg::RESP_OKAY);
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'h40F0_4004, ifr_pkg::RESP_OKAY);
    wr(ifr_pkg::OFF_AUXDATA, 32'hA1B2_C3D4, ifr_pkg::RESP_OKAY);
    wait_idle(500);
    verify('{32'h0, 0, '{4, 0, 0, 0, 0, 0, 0}, 4'hC});
    wr(ifr_pkg::OFF_AUXCMD, 32'h10F, ifr_pkg::RESP_OKAY);
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'hC3F0_4004, ifr_pkg::RESP_OKAY);
    wr(ifr_pkg::OFF_AUXDATA, 32'h0102_0304, ifr_pkg::RESP_OKAY);
    wait_idle(500);
    verify('{32'h0, 0, '{4, 4, 0, 0, 0, 0, 0}, 4'hD});
    wr(ifr_pkg::OFF_AUXCMD, 32'h77, ifr_pkg::RESP_OKAY);
    wr(ifr_pkg::OFF_AUXDATA, 32'h5555_AAAA, ifr_pkg::RESP_SLVERR);
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'h0000_0003, ifr_pkg::RESP_OKAY);
    wait_idle(100);
    verify('{32'h0, 0, '{0, 0, 0, 0, 0, 0, 0}, 4'h0});
    rd(ifr_pkg::OFF_STATUS, ifr_pkg::RESP_OKAY);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    wr(ifr_pkg::OFF_STATUS, 32'h8000_0000, ifr_pkg::RESP_OKAY);
    rd(ifr_pkg::OFF_STATUS, ifr_pkg::RESP_OKAY);
    chk(d & 32'h8000_0000, 32'h0);
    snapv = cnt;
    wr(ifr_pkg::OFF_ENTRY, 32'h40F0_0002, ifr_pkg::RESP_OKAY);
    wr(ifr_pkg::OFF_ENTRY, 32'h80F0_0003, ifr_pkg::RESP_OKAY);
    wait_idle(200);
    verify('{32'h0, 0, '{2, 3, 0, 5, 0, 0, 0}, 4'h0});
    chk(32'(dk), 32'hF);
    finish_test();
  end
endmodule // tb
bind ifr_top ifr_chk i_chk (.clk(clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .in_pop_q(in_pop_q), .c1_take_q(c1_take_q),
  .c2_take_q(c2_take_q), .c1_src_q(c1_src_q), .c2_src_q(c2_src_q), .drop_q(drop_q), .c1_flush_q(c1_flush_q),
  .c2_flush_q(c2_flush_q), .c2_size_ready_q(c2_size_ready_q), .busy_q(busy_q));
